/* File: hdl/mcc_edge_watch.sv */
// Edge watchdog that flags a source that stops toggling
`timescale 1ns/1ps
module mcc_edge_watch #(
  parameter int unsigned LIMIT = 30518
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic active,
  input wire logic sample,
  output logic fail_q
);
  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] cnt_q;
  logic prev_q;

  // Previous level of the watched source
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sample;
    end
  end

  // Silence counter, any edge clears the failure again
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      fail_q <= 1'b0;
    end else if (!active || (sample != prev_q)) begin
      cnt_q <= '0;
      fail_q <= 1'b0;
    end else if (cnt_q == LIM) begin
      fail_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule

/* File: hdl/mcc_main_clock_control.sv */
// Main clock controller: source select, prescaler, standby requests, failure detection, write protection
//
// What this block does
// - Failure test with main clock monitored raises failure that selects start-up source.
// - Stop every oscillator that is neither in use, requested nor kept on by run-in-standby.
// - Run-in-standby keeps an oscillator running in all modes but power-down.
// - With run-in-standby set, a request is served without start-up delay.
// - Main clock always runs in active and idle modes.
// - In standby, main clock runs only if requested or its run-in-standby is set.
// - In power-down, main clock runs until pending memory operations finish.
// - In sleep, failure detection acts only while its monitored source runs.
// - After reset, the watchdog reports no failure until one start-up period passes; the test bit is not blanked.
// - Protected write needs unlock key then write within four instructions.
// - Protected write without unlock is ignored.
// - Protection covers main controls, interrupt control, PLL and oscillator controls.
// - Clock output pin carries main clock when enabled and main clock runs.
// - Clock output enable set by one, cleared by zero or main failure.
// - Main source select codes 0 to 3, others reserved.
// - Prescaler enable zero passes main clock undivided, one divides it.
// - Division codes 0-5 and 8-C give the listed ratios, others reserved.
// - Failure control register holds monitor select, test bit and enable, reset zero.
// - Monitor select 0 main, 1 external high, 2 external low, others reserved.
// - Test bit written one forces failure while enable is set, written zero ends it.
// - Failure flag set by a failure, cleared by writing one.
// - Main clock failure overwrites main select with fuse start-up source.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module mcc_main_clock_control
  import mcc_pkg::*;
#(
  parameter int unsigned WATCH_LIMIT = mcc_pkg::WATCH_CYCLES,
  parameter int unsigned STARTUP_LIMIT = mcc_pkg::STARTUP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire mcc_pkg::mcc_bus_t bus_req,
  output logic [7:0] rdata_q,
  input wire logic unlock_key,
  input wire logic instr_step,
  input wire mcc_pkg::mcc_mode_t sleep_mode,
  input wire logic nvm_busy,
  input wire logic main_req,
  input wire logic [3:0] osc_req,
  input wire logic [3:0] osc_tick,
  input wire logic pll_locked,
  input wire logic [3:0] startup_fuse,
  output logic [3:0] osc_run_q,
  output logic [3:0] osc_ready_q,
  output logic main_run_q,
  output logic [3:0] main_sel_q,
  output logic per_tick_q,
  output logic clock_out_pin_q,
  output logic fail_irq_q
);
  localparam int unsigned SW = $clog2(STARTUP_LIMIT + 1);
  localparam logic [SW-1:0] STARTUP_END = SW'(STARTUP_LIMIT);

  // ==========================================================
  // Registers
  logic [7:0] sel_q, pre_q, fdc_q, irqc_q, hfc_q, hft_q, pll_q, ilc_q, elc_q, ehc_q;
  logic flag_q;
  logic [3:0] startup_q;
  logic unlock_q;
  logic [2:0] instr_cnt_q;
  logic [SW-1:0] blank_cnt_q;
  logic blank_done_q;
  logic fail_prev_q;

  logic wr, prot, wr_ok;
  logic [3:0] rsb;
  logic sleeping, main_run_d, watch_active, watch_fail, fail_now, fail_rise;
  logic [1:0] mon_idx;
  logic [DIV_W-1:0] ratio;

  assign wr = bus_req.wr;
  assign rsb = {ehc_q[RUN_STBY_BIT], elc_q[RUN_STBY_BIT], ilc_q[RUN_STBY_BIT], hfc_q[RUN_STBY_BIT]};
  assign sleeping = (sleep_mode != MODE_ACTIVE);

  // ==========================================================
  // Write protection
  // Offsets that need the unlock sequence
  always_comb begin
    unique case (bus_req.addr)
      OFF_SEL, OFF_PRE, OFF_FDC, OFF_IRQC, OFF_HFC, OFF_PLL, OFF_ILC, OFF_ELC, OFF_EHC: prot = 1'b1;
      default: prot = 1'b0;
    endcase
  end

  assign wr_ok = wr && (!prot || unlock_q);

  // Unlock window opened by the key, closed after four instructions
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      unlock_q <= 1'b0;
      instr_cnt_q <= 3'h0;
    end else if (unlock_key) begin
      unlock_q <= 1'b1;
      instr_cnt_q <= 3'h0;
    end else if (unlock_q && instr_step) begin
      instr_cnt_q <= instr_cnt_q + 3'h1;
      if (instr_cnt_q == UNLOCK_INSTR - 3'h1) begin
        unlock_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Failure detection
  // Start-up source fuse caught after reset release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      startup_q <= 4'h0;
      blank_cnt_q <= '0;
      blank_done_q <= 1'b0;
    end else begin
      if (!blank_done_q) begin
        startup_q <= startup_fuse;
      end
      if (blank_cnt_q == STARTUP_END) begin
        blank_done_q <= 1'b1;
      end else begin
        blank_cnt_q <= blank_cnt_q + {{(SW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Oscillator under watch
  always_comb begin
    unique case (fdc_q[3:2])
      MON_EHF: mon_idx = OSC_EHF;
      MON_ELO: mon_idx = OSC_ELO;
      default: mon_idx = sel_q[1:0];
    endcase
  end

  assign watch_active = fdc_q[FEN_BIT] && blank_done_q && (!sleeping || osc_run_q[mon_idx]);

  mcc_edge_watch #(
    .LIMIT(WATCH_LIMIT)
  ) u_watch (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .active(watch_active),
    .sample(osc_tick[mon_idx]),
    .fail_q(watch_fail)
  );

  assign fail_now = watch_fail || (fdc_q[FEN_BIT] && fdc_q[FTEST_BIT]);
  assign fail_rise = fail_now && !fail_prev_q;

  // Edge of the failure condition
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fail_prev_q <= 1'b0;
    end else begin
      fail_prev_q <= fail_now;
    end
  end

  // ==========================================================
  // Register updates
  // Main select and clock output enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= REG_RST;
    end else if (fail_rise && (fdc_q[3:2] == MON_MAIN)) begin
      sel_q <= {1'b0, 3'h0, startup_q};
    end else if (wr_ok && (bus_req.addr == OFF_SEL)) begin
      sel_q[CLK_OUT_EN_BIT] <= bus_req.wdata[CLK_OUT_EN_BIT];
      if (bus_req.wdata[3:0] <= SEL_MAX) begin
        sel_q[3:0] <= bus_req.wdata[3:0];
      end
    end
  end

  // Prescaler control, reserved division codes dropped
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= REG_RST;
    end else if (wr_ok && (bus_req.addr == OFF_PRE)) begin
      if (mcc_div_ratio(bus_req.wdata[4:1]) != 7'h00) begin
        pre_q <= bus_req.wdata & PRE_WMASK;
      end else begin
        pre_q[PRE_EN_BIT] <= bus_req.wdata[PRE_EN_BIT];
      end
    end
  end

  // Failure and interrupt control
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fdc_q <= REG_RST;
      irqc_q <= REG_RST;
    end else if (wr_ok) begin
      if (bus_req.addr == OFF_FDC) begin
        fdc_q <= bus_req.wdata & FDC_WMASK;
      end
      if (bus_req.addr == OFF_IRQC) begin
        irqc_q <= bus_req.wdata & IRQC_WMASK;
      end
    end
  end

  // Failure flag, a new failure wins over a clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (fail_rise) begin
      flag_q <= 1'b1;
    end else if (wr_ok && (bus_req.addr == OFF_FLAG) && bus_req.wdata[FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // Oscillator, trim and PLL controls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hfc_q <= HFC_RST;
      hft_q <= REG_RST;
      pll_q <= REG_RST;
      ilc_q <= REG_RST;
      elc_q <= REG_RST;
      ehc_q <= REG_RST;
    end else if (wr_ok) begin
      unique case (bus_req.addr)
        OFF_HFC: hfc_q <= bus_req.wdata;
        OFF_HFT: hft_q <= bus_req.wdata;
        OFF_PLL: pll_q <= bus_req.wdata;
        OFF_ILC: ilc_q <= bus_req.wdata;
        OFF_ELC: elc_q <= bus_req.wdata;
        OFF_EHC: ehc_q <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFF_SEL: rdata_q <= sel_q;
        OFF_PRE: rdata_q <= pre_q;
        OFF_FDC: rdata_q <= fdc_q;
        OFF_IRQC: rdata_q <= irqc_q;
        OFF_FLAG: rdata_q <= {7'h00, flag_q};
        OFF_STAT: rdata_q <= {2'h0, pll_locked, osc_ready_q[3], osc_ready_q[2], osc_ready_q[1], osc_ready_q[0],
                              !osc_ready_q[sel_q[1:0]]};
        OFF_HFC: rdata_q <= hfc_q;
        OFF_HFT: rdata_q <= hft_q;
        OFF_PLL: rdata_q <= pll_q;
        OFF_ILC: rdata_q <= ilc_q;
        OFF_ELC: rdata_q <= elc_q;
        OFF_EHC: rdata_q <= ehc_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================================
  // Sleep behaviour and oscillator requests
  // Main clock run decision per mode
  always_comb begin
    unique case (sleep_mode)
      MODE_ACTIVE, MODE_IDLE: main_run_d = 1'b1;
      MODE_STANDBY: main_run_d = main_req || rsb[sel_q[1:0]];
      MODE_PDOWN: main_run_d = nvm_busy;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      main_run_q <= 1'b1;
      main_sel_q <= 4'h0;
    end else begin
      main_run_q <= main_run_d;
      main_sel_q <= sel_q[3:0];
    end
  end

  // Per oscillator run enable and start-up timer
  for (genvar i = 0; i < NUM_OSC; i++) begin : g_osc
    logic used;
    logic [SW-1:0] start_cnt_q;
    assign used = main_run_d && (sel_q[1:0] == 2'(i));

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        osc_run_q[i] <= (i == 0);
      end else begin
        osc_run_q[i] <= used || osc_req[i] || (rsb[i] && (sleep_mode != MODE_PDOWN));
      end
    end

    // A free running oscillator is already ready when a request comes
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        start_cnt_q <= '0;
        osc_ready_q[i] <= 1'b0;
      end else if (!osc_run_q[i]) begin
        start_cnt_q <= '0;
        osc_ready_q[i] <= 1'b0;
      end else if (start_cnt_q == STARTUP_END) begin
        osc_ready_q[i] <= 1'b1;
      end else begin
        start_cnt_q <= start_cnt_q + {{(SW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // Prescaler and outputs
  assign ratio = pre_q[PRE_EN_BIT] ? mcc_div_ratio(pre_q[4:1]) : 7'h01;

  mcc_prescaler #(
    .W(DIV_W)
  ) u_pre (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ratio(ratio),
    .tick_q(per_tick_q)
  );

  // Clock output gate and interrupt request
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clock_out_pin_q <= 1'b0;
      fail_irq_q <= 1'b0;
    end else begin
      clock_out_pin_q <= sel_q[CLK_OUT_EN_BIT] && main_run_q;
      fail_irq_q <= flag_q && irqc_q[0];
    end
  end

  // ==========================================================
  // Assertions
  sequence s_main_fail;
    fail_rise && (fdc_q[3:2] == MON_MAIN);
  endsequence

  property p_test_switch;
    @(posedge ref_clk) disable iff (!resetn)
    s_main_fail |=> (sel_q[3:0] == $past(startup_q)) && !sel_q[CLK_OUT_EN_BIT] ##1 (main_sel_q == $past(sel_q[3:0]));
  endproperty
  a_test_switch: assert property (p_test_switch) else $error("main failure did not select start-up source");

  property p_flag_set;
    @(posedge ref_clk) disable iff (!resetn)
    fail_rise |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("failure did not set flag");

  property p_locked_write;
    @(posedge ref_clk) disable iff (!resetn)
    wr && (bus_req.addr == OFF_PRE) && !unlock_q |=> $stable(pre_q);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("protected write without unlock took effect");

  property p_reserved_sel;
    @(posedge ref_clk) disable iff (!resetn)
    wr_ok && (bus_req.addr == OFF_SEL) && (bus_req.wdata[3:0] > SEL_MAX) && !fail_rise |=> $stable(sel_q[3:0]);
  endproperty
  a_reserved_sel: assert property (p_reserved_sel) else $error("reserved select code changed source");

  property p_main_awake;
    @(posedge ref_clk) disable iff (!resetn)
    (sleep_mode == MODE_ACTIVE) || (sleep_mode == MODE_IDLE) |=> main_run_q;
  endproperty
  a_main_awake: assert property (p_main_awake) else $error("main clock stopped while awake");

  property p_pdown;
    @(posedge ref_clk) disable iff (!resetn)
    (sleep_mode == MODE_PDOWN) |=> (main_run_q == $past(nvm_busy));
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down main clock not tied to memory activity");

  property p_clock_output_enable;
    @(posedge ref_clk) disable iff (!resetn)
    ##1 clock_out_pin_q |-> $past(sel_q[CLK_OUT_EN_BIT]) && $past(main_run_q);
  endproperty
  a_clock_output_enable: assert property (p_clock_output_enable) else $error("clock output without enable and running clock");

  property p_blank;
    @(posedge ref_clk) disable iff (!resetn)
    !blank_done_q |=> !watch_fail;
  endproperty
  a_blank: assert property (p_blank) else $error("failure reported during start-up blanking");

  property p_unlock_close;
    @(posedge ref_clk) disable iff (!resetn)
    unlock_key ##1 (!unlock_key && instr_step)[*4] |=> !unlock_q;
  endproperty
  a_unlock_close: assert property (p_unlock_close) else $error("unlock window outlived four instructions");
endmodule

/* File: hdl/mcc_pkg.sv */
// Shared constants, types and helpers of the main clock controller
package mcc_pkg;

  // ==========================================================
  // Register offsets
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_SEL = 6'h00;
  localparam logic [5:0] OFF_PRE = 6'h01;
  localparam logic [5:0] OFF_FDC = 6'h02;
  localparam logic [5:0] OFF_IRQC = 6'h03;
  localparam logic [5:0] OFF_FLAG = 6'h04;
  localparam logic [5:0] OFF_STAT = 6'h05;
  localparam logic [5:0] OFF_HFC = 6'h08;
  localparam logic [5:0] OFF_HFT = 6'h09;
  localparam logic [5:0] OFF_PLL = 6'h10;
  localparam logic [5:0] OFF_ILC = 6'h18;
  localparam logic [5:0] OFF_ELC = 6'h1c;
  localparam logic [5:0] OFF_EHC = 6'h20;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned CLK_OUT_EN_BIT = 7;
  localparam int unsigned RUN_STBY_BIT = 7;
  localparam int unsigned PRE_EN_BIT = 0;
  localparam int unsigned FTEST_BIT = 1;
  localparam int unsigned FEN_BIT = 0;
  localparam int unsigned FLAG_BIT = 0;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] HFC_RST = 8'h0c;
  localparam logic [7:0] SEL_WMASK = 8'h8f;
  localparam logic [7:0] PRE_WMASK = 8'h1f;
  localparam logic [7:0] FDC_WMASK = 8'h0f;
  localparam logic [7:0] IRQC_WMASK = 8'h81;

  // ==========================================================
  // Oscillator indices, which equal the main source select codes
  localparam int unsigned NUM_OSC = 4;
  localparam logic [1:0] OSC_IHF = 2'h0;
  localparam logic [1:0] OSC_ILO = 2'h1;
  localparam logic [1:0] OSC_ELO = 2'h2;
  localparam logic [1:0] OSC_EHF = 2'h3;
  localparam logic [3:0] SEL_MAX = 4'h3;
  localparam logic [1:0] MON_MAIN = 2'h0;
  localparam logic [1:0] MON_EHF = 2'h1;
  localparam logic [1:0] MON_ELO = 2'h2;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WATCH_TIME_NS = 305176;
  localparam int unsigned WATCH_CYCLES = (WATCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_CYCLES = 1024;
  localparam logic [2:0] UNLOCK_INSTR = 3'h4;
  localparam int unsigned DIV_W = 7;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {MODE_ACTIVE, MODE_IDLE, MODE_STANDBY, MODE_PDOWN} mcc_mode_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mcc_bus_t;

  // Division ratio of a division code, zero for a reserved code
  function automatic logic [6:0] mcc_div_ratio(input logic [3:0] code);
    logic [6:0] r;
    r = 7'h00;
    unique case (code)
      4'h0: r = 7'h02;
      4'h1: r = 7'h04;
      4'h2: r = 7'h08;
      4'h3: r = 7'h10;
      4'h4: r = 7'h20;
      4'h5: r = 7'h40;
      4'h8: r = 7'h06;
      4'h9: r = 7'h0a;
      4'ha: r = 7'h0c;
      4'hb: r = 7'h18;
      4'hc: r = 7'h30;
      default: r = 7'h00;
    endcase
    return r;
  endfunction

endpackage

/* File: hdl/mcc_prescaler.sv */
// Main clock prescaler producing a one-cycle peripheral tick
`timescale 1ns/1ps
module mcc_prescaler #(
  parameter int unsigned W = 7
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [W-1:0] ratio,
  output logic tick_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] last;

  // Terminal count, ratio one gives a tick every cycle
  assign last = ratio - {{(W-1){1'b0}}, 1'b1};

  // Free running divider counter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end
endmodule

/* File: verification/main_clock_control_tb.sv */
// Self-checking testbench of the main clock controller
`timescale 1ns/1ps
module main_clock_control_tb;
  import mcc_pkg::*;
  logic ref_clk, resetn, nvm_busy, main_req, pll_locked, unlock_key, instr_step;
  logic main_run_q, per_tick_q, clock_out_pin_q, fail_irq_q;
  logic [3:0] osc_req, startup_fuse, osc_run_q, osc_ready_q, main_sel_q, osc_tick;
  logic [7:0] rdata_q, rv;
  mcc_mode_t sleep_mode;
  mcc_bus_t bus_req;
  int fails, checks;
  // ==========================================================
  // Design and partner
  mcc_main_clock_control #(.WATCH_LIMIT(20), .STARTUP_LIMIT(8)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .bus_req(bus_req), .rdata_q(rdata_q), .unlock_key(unlock_key), .instr_step(instr_step),
    .sleep_mode(sleep_mode), .nvm_busy(nvm_busy), .main_req(main_req), .osc_req(osc_req),
    .osc_tick(osc_tick), .pll_locked(pll_locked), .startup_fuse(startup_fuse), .osc_run_q(osc_run_q),
    .osc_ready_q(osc_ready_q), .main_run_q(main_run_q), .main_sel_q(main_sel_q), .per_tick_q(per_tick_q),
    .clock_out_pin_q(clock_out_pin_q), .fail_irq_q(fail_irq_q));
  mcc_cpu_model cpu (.ref_clk(ref_clk), .rdata_q(rdata_q), .osc_run_q(osc_run_q), .bus_req(bus_req),
    .unlock_key(unlock_key), .instr_step(instr_step), .osc_tick(osc_tick));
  // Clock of 10 ns
  always #5 ref_clk = ~ref_clk;
  // ==========================================================
  // Compare, register compare, verdict
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    cpu.rd(a, rv);
    chk($sformatf("reg %h", a), rv, exp);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cycles between two ticks, bounded
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (per_tick_q !== 1'b1 && n < 200);
    if (n >= 200) begin
      fails++;
      stop_test();
    end
  endtask
  // Settle n cycles off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("main_run", main_run_q, 1'b1);
    chk("osc_run", osc_run_q, 4'h1);
    rchk(OFF_FDC, 8'h00);
    rchk(OFF_HFC, 8'h0c);
    rchk(6'h06, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_protect();
    logic [5:0] offs[7] = '{OFF_PRE, OFF_FDC, OFF_IRQC, OFF_PLL, OFF_ILC, OFF_ELC, OFF_EHC};
    cpu.wr(OFF_SEL, 8'h81);
    rchk(OFF_SEL, 8'h00);
    foreach (offs[i]) begin
      cpu.wr(offs[i], 8'h01);
      rchk(offs[i], 8'h00);
    end
    cpu.wr(OFF_HFC, 8'h01);
    rchk(OFF_HFC, HFC_RST);
    cpu.pwr(OFF_SEL, 8'h81, 3);
    rchk(OFF_SEL, 8'h81);
    chk("clock_out_pin", clock_out_pin_q, 1'b1);
    cpu.pwr(OFF_SEL, 8'h01, 4);
    rchk(OFF_SEL, 8'h81);
    cpu.pwr(OFF_SEL, 8'h05, 0);
    rchk(OFF_SEL, 8'h01);
    for (int c = 3; c >= 0; c--) begin
      cpu.pwr(OFF_SEL, 8'(c), 0);
      settle(2);
      chk("main_sel", main_sel_q, 4'(c));
    end
    $display("test protect done");
  endtask
  task automatic t_presc();
    logic [3:0] codes[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
    int ratio[11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    int n;
    foreach (codes[i]) begin
      cpu.pwr(OFF_PRE, {3'h0, codes[i], 1'b1}, 0);
      gap(n);
      gap(n);
      chk("ratio", 8'(n), 8'(ratio[i]));
    end
    cpu.pwr(OFF_PRE, 8'h0d, 0);
    rchk(OFF_PRE, 8'h19);
    cpu.pwr(OFF_PRE, 8'h00, 0);
    gap(n);
    gap(n);
    chk("undivided", 8'(n), 8'h01);
    $display("test prescaler done");
  endtask
  task automatic t_modes();
    mcc_mode_t md[6] = '{MODE_ACTIVE, MODE_IDLE, MODE_STANDBY, MODE_STANDBY, MODE_PDOWN, MODE_PDOWN};
    logic [5:0] rq = 6'b001000;
    logic [5:0] nb = 6'b010000;
    logic [5:0] ex = 6'b011011;
    foreach (md[i]) begin
      sleep_mode <= md[i];
      main_req <= rq[i];
      nvm_busy <= nb[i];
      settle(3);
      chk("main_run", main_run_q, ex[i]);
    end
    sleep_mode <= MODE_STANDBY;
    settle(3);
    chk("osc_run idle", osc_run_q, 4'h0);
    cpu.pwr(OFF_ILC, 8'h80, 0);
    settle(20);
    chk("osc_run stdby", osc_run_q[1], 1'b1);
    osc_req[1] <= 1'b1;
    settle(1);
    chk("osc_ready", osc_ready_q[1], 1'b1);
    osc_req[1] <= 1'b0;
    cpu.pwr(OFF_HFC, 8'h8c, 0);
    settle(3);
    chk("main_run stdby", main_run_q, 1'b1);
    sleep_mode <= MODE_PDOWN;
    settle(3);
    chk("osc_run pdown", osc_run_q[1], 1'b0);
    sleep_mode <= MODE_ACTIVE;
    settle(3);
    $display("test modes done");
  endtask
  task automatic t_fail();
    cpu.pwr(OFF_SEL, 8'h82, 0);
    cpu.pwr(OFF_IRQC, 8'h01, 0);
    settle(10);
    cpu.pwr(OFF_FDC, 8'h03, 0);
    settle(3);
    chk("main_sel", main_sel_q, startup_fuse);
    chk("clock_out_pin", clock_out_pin_q, 1'b0);
    chk("fail_irq", fail_irq_q, 1'b1);
    rchk(OFF_SEL, 8'h01);
    rchk(OFF_FDC, 8'h03);
    cpu.pwr(OFF_FDC, 8'h01, 0);
    cpu.wr(OFF_FLAG, 8'h00);
    rchk(OFF_FLAG, 8'h01);
    cpu.wr(OFF_FLAG, 8'h01);
    rchk(OFF_FLAG, 8'h00);
    cpu.pwr(OFF_FDC, 8'h0b, 0);
    settle(2);
    rchk(OFF_FLAG, 8'h01);
    rchk(OFF_SEL, 8'h01);
    $display("test failure done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    nvm_busy = 1'b0;
    main_req = 1'b0;
    pll_locked = 1'b0;
    osc_req = 4'h0;
    startup_fuse = 4'h1;
    sleep_mode = MODE_ACTIVE;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    settle(2);
    t_reset();
    t_protect();
    t_presc();
    t_modes();
    t_fail();
    stop_test();
  end
endmodule

/* File: verification/mcc_cpu_model.sv */
// Processor bus, unlock and oscillator model facing the main clock controller
`timescale 1ns/1ps
module mcc_cpu_model (
  input wire logic ref_clk,
  input wire logic [7:0] rdata_q,
  input wire logic [3:0] osc_run_q,
  output mcc_pkg::mcc_bus_t bus_req,
  output logic unlock_key,
  output logic instr_step,
  output logic [3:0] osc_tick
);
  import mcc_pkg::*;
  // ==========================================================
  // Idle levels at time zero
  initial begin
    bus_req = '0;
    unlock_key = 1'b0;
    instr_step = 1'b0;
    osc_tick = 4'h0;
  end
  // Oscillators toggle only while enabled, a stopped one holds still
  always @(posedge ref_clk) begin
    osc_tick <= osc_tick ^ osc_run_q;
  end
  // ==========================================================
  // One plain write cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  // Key pulse, n instruction steps, then the protected write
  task automatic pwr(input logic [5:0] a, input logic [7:0] d, input int n);
    @(posedge ref_clk);
    unlock_key <= 1'b1;
    @(posedge ref_clk);
    unlock_key <= 1'b0;
    instr_step <= (n > 0);
    repeat (n) @(posedge ref_clk);
    instr_step <= 1'b0;
    wr(a, d);
  endtask
  // One read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata_q;
  endtask
endmodule
